// [rtl/tsdr_pkg.sv]
// Package for the tile status and debug register bank.
// Assumes word-indexed processor-status addresses, one register a word.
package tsdr_pkg;

  // Processor-status register indices, as addressed by the access port.
  localparam logic [7:0] TSDR_OFF_TILE_WIRE_OSC = 8'h08;
  localparam logic [7:0] TSDR_OFF_PERIPH_CELL_OSC = 8'h09;
  localparam logic [7:0] TSDR_OFF_PERIPH_WIRE_OSC = 8'h0A;
  localparam logic [7:0] TSDR_OFF_MEM_SIZE = 8'h0C;
  localparam logic [7:0] TSDR_OFF_STATUS_SNAP = 8'h10;
  localparam logic [7:0] TSDR_OFF_PC_SNAP = 8'h11;
  localparam logic [7:0] TSDR_OFF_SP_SNAP = 8'h12;
  localparam logic [7:0] TSDR_OFF_THREAD_SEL = 8'h13;
  localparam logic [7:0] TSDR_OFF_INDEX_SEL = 8'h14;
  localparam logic [7:0] TSDR_OFF_HALT_CAUSE = 8'h15;

  // Widths of the live fields.
  localparam int TSDR_OSC_W = 16;
  localparam int TSDR_STATUS_W = 11;
  localparam int TSDR_THREAD_W = 8;
  localparam int TSDR_INDEX_W = 5;
  localparam int TSDR_CAUSE_W = 3;
  localparam int TSDR_HWIDX_W = 2;
  localparam int TSDR_NUM_OSC = 3;
  localparam int TSDR_NUM_HW = 4;

  // Status snapshot bit positions.
  localparam int TSDR_EVENTS_ON_BIT = 0;
  localparam int TSDR_INTERRUPTS_ON_BIT = 1;
  localparam int TSDR_IN_ENABLE_SEQ_BIT = 2;
  localparam int TSDR_IN_HANDLER_BIT = 3;
  localparam int TSDR_KERNEL_MODE_BIT = 4;
  localparam int TSDR_PAUSED_WAITING_BIT = 6;
  localparam int TSDR_FAST_ISSUE_BIT = 7;
  localparam int TSDR_ISSUE_MODE_BIT = 8;
  localparam int TSDR_KENTRY_MODE_BIT = 9;
  localparam int TSDR_ADDR_SPACE_BIT = 10;

  // Bits of the status snapshot that the debugger may overwrite; bit 8 is
  // a read-only view and bit 5 is reserved.
  localparam logic [10:0] TSDR_STATUS_WR_MASK = 11'h6DF;

  // Halt cause record field positions.
  localparam int TSDR_HALT_THREAD_LSB = 8;
  localparam int TSDR_HALT_INDEX_LSB = 16;

  // Memory size field starts above two reserved bits.
  localparam int TSDR_MEM_SIZE_LSB = 2;

  // Cause codes of the debug interrupt.
  typedef enum logic [2:0] {
    TSDR_CAUSE_NONE = 3'h0,
    TSDR_CAUSE_HOST = 3'h1,
    TSDR_CAUSE_DEBUG_CALL_INSTR = 3'h2,
    TSDR_CAUSE_IBREAK = 3'h3,
    TSDR_CAUSE_DWATCH = 3'h4,
    TSDR_CAUSE_RWATCH = 3'h5
  } tsdr_cause_t;

endpackage

// [rtl/tsdr_osc_counter.sv]
// Counter for one ring oscillator, advanced by its synchronous tick.
// Assumes the tick is already in the core clock domain, one pulse per edge.
`timescale 1ns/100ps
module tsdr_osc_counter
  import tsdr_pkg::*;
#(
  parameter int W = TSDR_OSC_W
) (
  input wire logic clk,
  input wire logic por_n,
  input wire logic ce,
  input wire logic run,
  input wire logic tick,
  output logic [W-1:0] count
);

  // The whole state of this counter.
  typedef struct packed {
    logic [W-1:0] cnt;
  } tsdr_osc_state_t;

  tsdr_osc_state_t st_r;
  tsdr_osc_state_t st_nxt;

  // Refuse widths that the count cannot hold in one bus word.
  if (W < 1 || W > 32) begin : g_bad_width
    $error("tsdr_osc_counter: width must be 1 to 32");
  end

  // Count one step per oscillator tick while the oscillator runs.
  always_comb begin
    st_nxt = st_r;
    if (run && tick) begin
      st_nxt.cnt = st_r.cnt + W'(1);
    end
  end

  // Only power-up clears the count, so a system reset keeps it readable.
  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      st_r <= '0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign count = st_r.cnt;

  property p_osc_step;
    @(posedge clk) disable iff (!por_n)
      ce && run && tick |=> count == W'($past(count) + W'(1));
  endproperty
  a_osc_step: assert property (p_osc_step)
    else $error("osc count missed a step");

  property p_osc_hold;
    @(posedge clk) disable iff (!por_n)
      !(ce && run && tick) |=> count == $past(count);
  endproperty
  a_osc_hold: assert property (p_osc_hold)
    else $error("osc count moved while stopped");

endmodule

// [rtl/tsdr_cause_encode.sv]
// Encoder that turns debug-entry requests into a cause, thread and index.
// Assumes at most one logical thread is named per entry request.
`timescale 1ns/100ps
module tsdr_cause_encode
  import tsdr_pkg::*;
#(
  parameter int NHW = TSDR_NUM_HW
) (
  input wire logic host_req,
  input wire logic debug_call_instr_req,
  input wire logic [NHW-1:0] ibreak_hit,
  input wire logic [NHW-1:0] dwatch_hit,
  input wire logic [NHW-1:0] rwatch_hit,
  input wire logic [TSDR_THREAD_W-1:0] trig_thread,
  output logic [TSDR_CAUSE_W-1:0] cause,
  output logic [TSDR_THREAD_W-1:0] thread,
  output logic [TSDR_HWIDX_W-1:0] hw_index
);

  // Refuse more units than the index field can name.
  if (NHW < 1 || NHW > (1 << TSDR_HWIDX_W)) begin : g_bad_units
    $error("tsdr_cause_encode: unit count does not fit the index field");
  end

  // Lowest set bit of a hit vector; zero when none is set.
  function automatic logic [TSDR_HWIDX_W-1:0] lowest(
    input logic [NHW-1:0] v
  );
    logic [TSDR_HWIDX_W-1:0] r;
    r = '0;
    for (int i = NHW - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = TSDR_HWIDX_W'(i);
      end
    end
    return r;
  endfunction

  // Host wins over the others so a stuck program cannot hide the host.
  always_comb begin
    cause = TSDR_CAUSE_NONE;
    thread = trig_thread;
    hw_index = '0;
    if (host_req) begin
      cause = TSDR_CAUSE_HOST;
      thread = '0;
    end else if (debug_call_instr_req) begin
      cause = TSDR_CAUSE_DEBUG_CALL_INSTR;
    end else if (|ibreak_hit) begin
      cause = TSDR_CAUSE_IBREAK;
      hw_index = lowest(ibreak_hit);
    end else if (|dwatch_hit) begin
      cause = TSDR_CAUSE_DWATCH;
      hw_index = lowest(dwatch_hit);
    end else if (|rwatch_hit) begin
      cause = TSDR_CAUSE_RWATCH;
      hw_index = lowest(rwatch_hit);
    end
  end

endmodule

// [rtl/tsdr_regs.sv]
// Tile status and debug register bank behind the processor-status port.
// Assumes one core clock; oscillator ticks and requests arrive synchronous.
`timescale 1ns/100ps
// Behaviour
// - three read-only 16-bit oscillator counts
// - counts survive system reset, zero at power-up
// - read-only memory size in bits 31:2
// - capture saved status word on debug entry
// - status bits 0-4 flags and kernel mode
// - bit 7 fast issue, bit 6 paused
// - bits 8-10 issue modes and address space
// - capture saved program counter on entry
// - capture saved stack pointer on entry
// - 8-bit thread select for register read
// - 5-bit register index for register read
// - 3-bit cause code, reset zero
// - cause thread in 15:8, zero for host
// - unit index in 17:16, lowest wins
// - counts advance only while own oscillator runs
module tsdr_regs
  import tsdr_pkg::*;
#(
  parameter logic [31:0] MEM_BYTES = 32'h0004_0000,
  parameter int NHW = TSDR_NUM_HW
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic por_n,
  input wire logic ce,
  input wire logic [7:0] ps_addr,
  input wire logic ps_wr,
  input wire logic ps_rd,
  input wire logic [31:0] ps_wdata,
  output logic [31:0] ps_rdata,
  output logic ps_rvalid,
  input wire logic debug_mode,
  input wire logic debug_enter,
  input wire logic [TSDR_STATUS_W-1:0] saved_status_word,
  input wire logic [31:0] saved_program_counter,
  input wire logic [31:0] saved_stack_pointer,
  input wire logic host_req,
  input wire logic debug_call_instr_req,
  input wire logic [NHW-1:0] ibreak_hit,
  input wire logic [NHW-1:0] dwatch_hit,
  input wire logic [NHW-1:0] rwatch_hit,
  input wire logic [TSDR_THREAD_W-1:0] trig_thread,
  input wire logic [TSDR_NUM_OSC-1:0] osc_run,
  input wire logic [TSDR_NUM_OSC-1:0] osc_tick,
  output logic [TSDR_THREAD_W-1:0] regread_thread_field,
  output logic [TSDR_INDEX_W-1:0] regread_index_field
);

  // Refuse a memory size that the word-aligned field cannot show.
  if (MEM_BYTES[TSDR_MEM_SIZE_LSB-1:0] != '0) begin : g_bad_mem
    $error("tsdr_regs: memory size must be a whole number of words");
  end

  // The whole register state of the bank, apart from the counters.
  typedef struct packed {
    logic [TSDR_STATUS_W-1:0] status;
    logic [31:0] pc;
    logic [31:0] sp;
    logic [TSDR_THREAD_W-1:0] tsel;
    logic [TSDR_INDEX_W-1:0] isel;
    logic [TSDR_CAUSE_W-1:0] cause;
    logic [TSDR_THREAD_W-1:0] cthread;
    logic [TSDR_HWIDX_W-1:0] cindex;
    logic [31:0] rdata;
    logic rvalid;
  } tsdr_state_t;

  tsdr_state_t st_r;
  tsdr_state_t st_nxt;

  // Live counts of the three oscillators.
  logic [TSDR_OSC_W-1:0] osc_count_value [TSDR_NUM_OSC];

  // Encoded cause of a debug entry in this cycle.
  logic [TSDR_CAUSE_W-1:0] enc_cause;
  logic [TSDR_THREAD_W-1:0] enc_thread;
  logic [TSDR_HWIDX_W-1:0] enc_index;

  // Accepted debug write; outside debug mode writes are dropped silently.
  logic dbg_wr;
  assign dbg_wr = ps_wr && debug_mode;

  // True when a write in this cycle lands on the given register.
  function automatic logic wr_hit(
    input logic we,
    input logic [7:0] addr,
    input logic [7:0] off
  );
    return we && (addr == off);
  endfunction

  // Zero-extend a 16-bit count into a bus word.
  function automatic logic [31:0] osc_word(
    input logic [TSDR_OSC_W-1:0] v
  );
    return {{(32 - TSDR_OSC_W){1'b0}}, v};
  endfunction

  // One counter per oscillator; each keeps its value over system reset.
  for (genvar g = 0; g < TSDR_NUM_OSC; g++) begin : g_osc
    tsdr_osc_counter #(
      .W(TSDR_OSC_W)
    ) u_cnt (
      .clk(clk),
      .por_n(por_n),
      .ce(ce),
      .run(osc_run[g]),
      .tick(osc_tick[g]),
      .count(osc_count_value[g])
    );
  end

  // Cause, thread and unit index of the current entry request.
  tsdr_cause_encode #(
    .NHW(NHW)
  ) u_cause (
    .host_req(host_req),
    .debug_call_instr_req(debug_call_instr_req),
    .ibreak_hit(ibreak_hit),
    .dwatch_hit(dwatch_hit),
    .rwatch_hit(rwatch_hit),
    .trig_thread(trig_thread),
    .cause(enc_cause),
    .thread(enc_thread),
    .hw_index(enc_index)
  );

  // Next-state logic: writes first, then debug-entry capture on top.
  // Capture is written last so it beats a debugger write in the same cycle.
  always_comb begin
    st_nxt = st_r;
    st_nxt.rvalid = ps_rd;
    if (wr_hit(dbg_wr, ps_addr, TSDR_OFF_STATUS_SNAP)) begin
      st_nxt.status = (st_r.status & ~TSDR_STATUS_WR_MASK) |
                      (ps_wdata[TSDR_STATUS_W-1:0] & TSDR_STATUS_WR_MASK);
    end
    if (wr_hit(dbg_wr, ps_addr, TSDR_OFF_PC_SNAP)) begin
      st_nxt.pc = ps_wdata;
    end
    if (wr_hit(dbg_wr, ps_addr, TSDR_OFF_SP_SNAP)) begin
      st_nxt.sp = ps_wdata;
    end
    if (wr_hit(dbg_wr, ps_addr, TSDR_OFF_THREAD_SEL)) begin
      st_nxt.tsel = ps_wdata[TSDR_THREAD_W-1:0];
    end
    if (wr_hit(dbg_wr, ps_addr, TSDR_OFF_INDEX_SEL)) begin
      st_nxt.isel = ps_wdata[TSDR_INDEX_W-1:0];
    end
    if (wr_hit(dbg_wr, ps_addr, TSDR_OFF_HALT_CAUSE)) begin
      st_nxt.cause = ps_wdata[TSDR_CAUSE_W-1:0];
      st_nxt.cthread =
        ps_wdata[TSDR_HALT_THREAD_LSB +: TSDR_THREAD_W];
      st_nxt.cindex = ps_wdata[TSDR_HALT_INDEX_LSB +: TSDR_HWIDX_W];
    end
    if (debug_enter) begin
      st_nxt.status = saved_status_word;
      // Bit 5 is reserved and must never read back as one.
      st_nxt.status[5] = 1'b0;
      st_nxt.pc = saved_program_counter;
      st_nxt.sp = saved_stack_pointer;
      st_nxt.cause = enc_cause;
      st_nxt.cthread = enc_thread;
      st_nxt.cindex = enc_index;
    end
    // Read mux; unmapped indices and reserved bits read as zero.
    st_nxt.rdata = '0;
    if (ps_rd) begin
      unique case (ps_addr)
        TSDR_OFF_TILE_WIRE_OSC: st_nxt.rdata = osc_word(osc_count_value[0]);
        TSDR_OFF_PERIPH_CELL_OSC: begin
          st_nxt.rdata = osc_word(osc_count_value[1]);
        end
        TSDR_OFF_PERIPH_WIRE_OSC: begin
          st_nxt.rdata = osc_word(osc_count_value[2]);
        end
        TSDR_OFF_MEM_SIZE: begin
          st_nxt.rdata = {MEM_BYTES[31:TSDR_MEM_SIZE_LSB],
                          {TSDR_MEM_SIZE_LSB{1'b0}}};
        end
        TSDR_OFF_STATUS_SNAP: begin
          st_nxt.rdata = {{(32 - TSDR_STATUS_W){1'b0}}, st_r.status};
        end
        TSDR_OFF_PC_SNAP: st_nxt.rdata = st_r.pc;
        TSDR_OFF_SP_SNAP: st_nxt.rdata = st_r.sp;
        TSDR_OFF_THREAD_SEL: begin
          st_nxt.rdata = {{(32 - TSDR_THREAD_W){1'b0}}, st_r.tsel};
        end
        TSDR_OFF_INDEX_SEL: begin
          st_nxt.rdata = {{(32 - TSDR_INDEX_W){1'b0}}, st_r.isel};
        end
        TSDR_OFF_HALT_CAUSE: begin
          st_nxt.rdata = {14'h0000, st_r.cindex, st_r.cthread, 5'h00,
                          st_r.cause};
        end
        default: st_nxt.rdata = '0;
      endcase
    end
  end

  // System reset clears the debug state; the counters are not touched.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  // Outputs come straight from the state flops.
  assign ps_rdata = st_r.rdata;
  assign ps_rvalid = st_r.rvalid;
  assign regread_thread_field = st_r.tsel;
  assign regread_index_field = st_r.isel;

  property p_status_capture;
    @(posedge clk) disable iff (!rst_n)
      ce && debug_enter |=>
        st_r.status == ($past(saved_status_word) & 11'h7DF);
  endproperty
  a_status_capture: assert property (p_status_capture)
    else $error("status snapshot not captured");

  property p_pc_capture;
    @(posedge clk) disable iff (!rst_n)
      ce && debug_enter ##1 ce && ps_rd && ps_addr == TSDR_OFF_PC_SNAP
        |=> ps_rdata == $past(saved_program_counter, 2);
  endproperty
  a_pc_capture: assert property (p_pc_capture)
    else $error("saved pc not readable after entry");

  property p_sp_capture;
    @(posedge clk) disable iff (!rst_n)
      ce && debug_enter |=> st_r.sp == $past(saved_stack_pointer);
  endproperty
  a_sp_capture: assert property (p_sp_capture)
    else $error("saved sp not captured");

  property p_no_write_outside_debug;
    @(posedge clk) disable iff (!rst_n)
      ce && ps_wr && !debug_mode && !debug_enter |=>
        st_r.tsel == $past(st_r.tsel) && st_r.isel == $past(st_r.isel);
  endproperty
  a_no_write_outside_debug: assert property(p_no_write_outside_debug)
    else $error("write accepted outside debug mode");

  property p_thread_write;
    @(posedge clk) disable iff (!rst_n)
      ce && debug_mode && ps_wr && ps_addr == TSDR_OFF_THREAD_SEL
        |=> regread_thread_field == $past(ps_wdata[7:0]);
  endproperty
  a_thread_write: assert property (p_thread_write)
    else $error("thread select not written");

  property p_index_write;
    @(posedge clk) disable iff (!rst_n)
      ce && debug_mode && ps_wr && ps_addr == TSDR_OFF_INDEX_SEL
        |=> regread_index_field == $past(ps_wdata[4:0]);
  endproperty
  a_index_write: assert property (p_index_write)
    else $error("index select not written");

  property p_osc_upper_zero;
    @(posedge clk) disable iff (!rst_n)
      ce && ps_rd && ps_addr inside {[TSDR_OFF_TILE_WIRE_OSC :
                                      TSDR_OFF_PERIPH_WIRE_OSC]}
        |=> ps_rvalid && ps_rdata[31:16] == 16'h0000;
  endproperty
  a_osc_upper_zero: assert property (p_osc_upper_zero)
    else $error("oscillator read has upper bits set");

  property p_mem_size;
    @(posedge clk) disable iff (!rst_n)
      ce && ps_rd && ps_addr == TSDR_OFF_MEM_SIZE
        |=> ps_rdata == {MEM_BYTES[31:2], 2'b00};
  endproperty
  a_mem_size: assert property (p_mem_size)
    else $error("memory size read wrong");

  property p_host_cause;
    @(posedge clk) disable iff (!rst_n)
      ce && debug_enter && host_req |=>
        st_r.cause == 3'h1 && st_r.cthread == '0 && st_r.cindex == '0;
  endproperty
  a_host_cause: assert property (p_host_cause)
    else $error("host cause fields wrong");

  property p_ibreak_lowest;
    @(posedge clk) disable iff (!rst_n)
      ce && debug_enter && !host_req && !debug_call_instr_req && ibreak_hit[0]
        |=> st_r.cause == 3'h3 && st_r.cindex == 2'h0;
  endproperty
  a_ibreak_lowest: assert property (p_ibreak_lowest)
    else $error("breakpoint index not lowest");

  property p_kernel_view;
    @(posedge clk) disable iff (!rst_n)
      ce && debug_mode && ps_wr && !debug_enter &&
        ps_addr == TSDR_OFF_STATUS_SNAP
        |=> st_r.status[8] == $past(st_r.status[8]) &&
            st_r.status[4] == $past(ps_wdata[4]);
  endproperty
  a_kernel_view: assert property (p_kernel_view)
    else $error("status write mask wrong");

endmodule

// [dv/testbench.sv]
// Self-checking bench for the tile status and debug register bank.
// Assumes the bank answers a read one cycle after the strobe is taken.
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin \
  n_checks++; \
  if ((got) !== (ex)) begin \
    failures++; \
    $display("wrong value %s expected %h seen %h", nm, ex, got); \
  end \
end
module testbench;
  import tsdr_pkg::*;
  // Memory size picked for the bench; any multiple of four will do.
  localparam logic [31:0] MEM = 32'h0001_2340;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic por_n = 1'b0;
  logic ce = 1'b1;
  logic [7:0] ps_addr = 8'h00;
  logic ps_wr = 1'b0;
  logic ps_rd = 1'b0;
  logic [31:0] ps_wdata = 32'h0000_0000;
  logic [31:0] ps_rdata;
  logic ps_rvalid;
  logic debug_mode = 1'b0;
  logic debug_enter = 1'b0;
  logic [10:0] sw = 11'h000;
  logic [31:0] pc = 32'h0000_0000;
  logic [31:0] sp = 32'h0000_0000;
  logic host_req = 1'b0;
  logic debug_call_instr_req = 1'b0;
  logic [3:0] ib = 4'h0;
  logic [3:0] dw = 4'h0;
  logic [3:0] rw = 4'h0;
  logic [7:0] th = 8'h00;
  logic [2:0] osc_run = 3'h0;
  logic [2:0] osc_tick = 3'h0;
  logic [7:0] thr_field;
  logic [4:0] idx_field;
  // Bench bookkeeping: counters, model state and scratch values.
  int failures = 0;
  int n_checks = 0;
  logic [15:0] cnt [3];
  logic [31:0] d;
  logic [31:0] e;
  logic [31:0] v;
  logic [31:0] st;
  logic [7:0] adr [12] = '{8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D,
                           8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15};
  logic [7:0] wadr [8] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15,
                           8'h08, 8'h0D};

  tsdr_regs #(.MEM_BYTES(MEM), .NHW(4)) dut (
    .clk(clk), .rst_n(rst_n), .por_n(por_n), .ce(ce),
    .ps_addr(ps_addr), .ps_wr(ps_wr), .ps_rd(ps_rd),
    .ps_wdata(ps_wdata), .ps_rdata(ps_rdata), .ps_rvalid(ps_rvalid),
    .debug_mode(debug_mode), .debug_enter(debug_enter),
    .saved_status_word(sw), .saved_program_counter(pc),
    .saved_stack_pointer(sp), .host_req(host_req),
    .debug_call_instr_req(debug_call_instr_req), .ibreak_hit(ib), .dwatch_hit(dw),
    .rwatch_hit(rw), .trig_thread(th), .osc_run(osc_run),
    .osc_tick(osc_tick), .regread_thread_field(thr_field),
    .regread_index_field(idx_field)
  );

  // Core clock, 5 ns period.
  always #2.5 clk = ~clk;

  // Prints the counts and the verdict, then stops the run.
  task automatic summarize;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // One read; a missing valid pulse turns the data unknown so it mismatches.
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    ps_addr = a;
    ps_rd = 1'b1;
    @(negedge clk);
    ps_rd = 1'b0;
    q = (ps_rvalid === 1'b1) ? ps_rdata : 'x;
    @(negedge clk);
  endtask

  // One write; the spare cycle keeps strobes from being re-raised at once.
  task automatic wr(input logic [7:0] a, input logic [31:0] val);
    ps_addr = a;
    ps_wdata = val;
    ps_wr = 1'b1;
    @(negedge clk);
    ps_wr = 1'b0;
    @(negedge clk);
  endtask

  // Reads the three counts back against the bench model.
  task automatic check_osc;
    for (int j = 0; j < 3; j++) begin
      rd(8'h08 + 8'(j), d);
      `CHK("osc count", {16'h0000, cnt[j]}, d)
    end
  endtask

  // A hit vector that is never empty; empty draws become the top unit.
  function automatic logic [3:0] nz();
    logic [3:0] r;
    r = 4'($urandom);
    return (r == 4'h0) ? 4'h8 : r;
  endfunction

  // Index of the lowest set bit, which is the unit that must be reported.
  function automatic logic [1:0] low(input logic [3:0] h);
    logic [1:0] i;
    i = 2'h0;
    for (int b = 3; b >= 0; b--) begin
      if (h[b]) begin
        i = 2'(b);
      end
    end
    return i;
  endfunction

  // Expected cause record for case k: host, call, break, data, resource.
  function automatic logic [31:0] cause_exp(input int k);
    logic [1:0] i;
    i = (k == 2) ? low(ib) : (k == 3) ? low(dw) : (k == 4) ? low(rw) : 2'h0;
    return {14'h0000, i, (k == 0) ? 8'h00 : th, 5'h00, 3'(k + 1)};
  endfunction

  // A hang cuts the run short as a failure.
  initial begin
    #(450_000);
    failures++;
    summarize();
  end

  initial begin
    void'($urandom(57));
    for (int j = 0; j < 3; j++) begin
      cnt[j] = 16'h0000;
    end
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    por_n = 1'b1;
    // Every register after reset; unmapped places read zero.
    foreach (adr[i]) begin
      rd(adr[i], d);
      e = (adr[i] == TSDR_OFF_MEM_SIZE) ? MEM : 32'h0000_0000;
      `CHK("reset value", e, d)
    end
    // Random ticks with the clock enable and run levels toggling.
    for (int i = 0; i < 400; i++) begin
      ce = 1'($urandom);
      osc_run = 3'($urandom);
      osc_tick = 3'($urandom);
      @(negedge clk);
      for (int j = 0; j < 3; j++) begin
        cnt[j] += 16'(ce & osc_run[j] & osc_tick[j]);
      end
    end
    // A full lap of the first count must wrap back, not saturate.
    ce = 1'b1;
    osc_run = 3'h1;
    osc_tick = 3'h1;
    repeat (65536) @(negedge clk);
    osc_run = 3'h0;
    osc_tick = 3'h0;
    repeat (10) @(negedge clk);
    check_osc();
    // A system reset must leave the counts alone.
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    check_osc();
    // Power-up reset clears them.
    por_n = 1'b0;
    repeat (2) @(negedge clk);
    por_n = 1'b1;
    cnt = '{16'h0000, 16'h0000, 16'h0000};
    check_osc();
    // Debug entries for every cause, lower causes competing each time.
    debug_mode = 1'b1;
    for (int k = 0; k < 6; k++) begin
      // Unit 0 always fires on the breakpoint entry, the lowest-index case.
      ib = (k > 2) ? 4'h0 : (k == 2) ? (nz() | 4'h1) : nz();
      dw = (k > 3) ? 4'h0 : nz();
      rw = (k > 4) ? 4'h0 : nz();
      host_req = (k == 0);
      debug_call_instr_req = (k <= 1);
      th = 8'($urandom);
      sw = 11'($urandom);
      pc = $urandom;
      sp = $urandom;
      // A debugger write landing on the entry edge must lose.
      if (k == 2) begin
        ps_addr = TSDR_OFF_PC_SNAP;
        ps_wdata = ~pc;
        ps_wr = 1'b1;
      end
      debug_enter = 1'b1;
      @(negedge clk);
      // The expected record needs the hit vectors as they stood at entry.
      e = cause_exp(k);
      {debug_enter, ps_wr, host_req, debug_call_instr_req} = 4'h0;
      {ib, dw, rw} = 12'h000;
      st = {21'h00_0000, sw} & 32'h0000_07DF;
      // The saved pc is read first, right in the cycle after entry.
      rd(TSDR_OFF_PC_SNAP, d);
      `CHK("pc snap", pc, d)
      rd(TSDR_OFF_STATUS_SNAP, d);
      `CHK("status snap", st, d)
      rd(TSDR_OFF_SP_SNAP, d);
      `CHK("sp snap", sp, d)
      rd(TSDR_OFF_HALT_CAUSE, d);
      if (k == 5) begin
        `CHK("no cause", 3'h0, d[2:0])
      end else begin
        `CHK("cause record", e, d)
      end
    end
    // Writes outside debug mode are dropped.
    debug_mode = 1'b0;
    wr(TSDR_OFF_THREAD_SEL, 32'hFFFF_FFFF);
    `CHK("thread field", 8'h00, thr_field)
    // Debugger writes in debug mode, reserved and read-only bits held.
    debug_mode = 1'b1;
    foreach (wadr[i]) begin
      v = $urandom;
      wr(wadr[i], v);
      case (wadr[i])
        TSDR_OFF_STATUS_SNAP: e = (v & 32'h0000_06DF) | (st & 32'h0000_0100);
        TSDR_OFF_THREAD_SEL: e = v & 32'h0000_00FF;
        TSDR_OFF_INDEX_SEL: e = v & 32'h0000_001F;
        TSDR_OFF_HALT_CAUSE: e = v & 32'h0003_FF07;
        8'h08, 8'h0D: e = 32'h0000_0000;
        default: e = v;
      endcase
      rd(wadr[i], d);
      `CHK("write back", e, d)
      if (wadr[i] == TSDR_OFF_THREAD_SEL) begin
        `CHK("thread port", v[7:0], thr_field)
      end
      if (wadr[i] == TSDR_OFF_INDEX_SEL) begin
        `CHK("index port", v[4:0], idx_field)
      end
    end
    summarize();
  end
endmodule
